// >>> sac_consts.vh
// Register offsets, field positions, reset values for the sensor alarm configuration block
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SAC_OFS_CTRL0 8'h17
`define SAC_OFS_V0_LIM 8'h19
`define SAC_OFS_V1_LIM 8'h1A
`define SAC_OFS_T_LIM 8'h1B
`define SAC_OFS_VID_EN 8'h1C
`define SAC_OFS_LIM_EN 8'h1D
`define SAC_OFS_RET_EN 8'h1E
`define SAC_OFS_STATUS 8'h40
`define SAC_OFS_V0_PEAK 8'h41
`define SAC_OFS_V0_FLOOR 8'h42
`define SAC_OFS_V1_PEAK 8'h43
`define SAC_OFS_V1_FLOOR 8'h44

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SAC_UPPER_MSB 6
`define SAC_UPPER_LSB 4
`define SAC_LOWER_MSB 2
`define SAC_LOWER_LSB 0
`define SAC_EN_MSB 3
`define SAC_EN_LSB 2
`define SAC_SEL_MSB 1
`define SAC_SEL_LSB 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SAC_RST_LIM 8'h62
`define SAC_RST_CTRL0 8'h3C
`define SAC_RST_VID_EN 8'h3F
`define SAC_RST_LIM_EN 8'h00
`define SAC_RST_RET_EN 8'h00
`define SAC_RST_PEAK 8'h00
`define SAC_RST_FLOOR 8'hFF
`define SAC_SENSE_ON 2'h3

`endif

// >>> sac_sensor_alarm_config.v
// Sensor limit registers, alarm enables, status flags and peak/floor tracking
//
// Notes on behaviour
// - Channel 0 upper limit bits 6:4, reset 6; above it sets high flag.
// - Channel 0 lower limit bits 2:0, reset 2; below it sets low flag.
// - Keep highest and lowest channel 0 readings for software readback.
// - Channel 1 upper limit bits 6:4, reset 6; above it sets high flag.
// - Channel 1 lower limit bits 2:0, reset 2; below it sets low flag.
// - Keep highest and lowest channel 1 readings for software readback.
// - Temperature upper limit bits 6:4, reset 6; above it sets high flag.
// - Temperature lower limit bits 2:0, reset 2; below it sets low flag.
// - Limit register bits 7 and 3 are reserved read/write, reset zero.
// - Video alarm enable bit 5 missing frame valid, reset 1.
// - Video alarm enable bits 4 sync and 3 lane control, reset 1.
// - Video alarm enable bits 2 header, 1 checksum, 0 length, reset 1.
// - Video alarm enable bits 7:6 reserved, reset zero.
// - Limit alarm enable bits 5 and 4 temperature over/under, reset 0.
// - Limit alarm enable bits 3:2 channel 1, 1:0 channel 0, reset 0.
// - Return alarm enable bits 6..3 timeout and fault enables, reset 0.
// - Return alarm enable bits 2 data, 1 CRC, 0 link detect; 7 reserved.
// - Two-bit select chooses which GPIO channels are voltage sensed.
// - Two-bit sensor enable, 11 on, 00 off, resets enabled.
`include "sac_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module sac_sensor_alarm_config (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_meas_valid,
  input wire [2:0] i_volt0_level,
  input wire [2:0] i_volt1_level,
  input wire [2:0] i_temp_level,
  input wire [5:0] i_video_fault,
  input wire [6:0] i_return_fault,
  output wire o_alarm
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [22:0] sync1_reg;
  reg [22:0] sync2_reg;
  wire [22:0] sync_in;
  assign sync_in = {i_return_fault, i_video_fault, i_temp_level, i_volt1_level,
                    i_volt0_level, i_meas_valid};

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync1_reg <= 23'h000000;
      sync2_reg <= 23'h000000;
    end else begin
      sync1_reg <= sync_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire meas_valid;
  wire [2:0] lvl [0:2];
  wire [5:0] video_fault;
  wire [6:0] return_fault;
  assign meas_valid = sync2_reg[0];
  assign lvl[0] = sync2_reg[3:1];
  assign lvl[1] = sync2_reg[6:4];
  assign lvl[2] = sync2_reg[9:7];
  assign video_fault = sync2_reg[15:10];
  assign return_fault = sync2_reg[22:16];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl0_reg;
  reg [7:0] lim_reg [0:2];
  reg [7:0] vid_en_reg;
  reg [7:0] lim_en_reg;
  reg [7:0] ret_en_reg;

  wire wr_ctrl0;
  wire wr_vid;
  wire wr_lim_en;
  wire wr_ret;
  assign wr_ctrl0 = i_wr && (i_addr == `SAC_OFS_CTRL0);
  assign wr_vid = i_wr && (i_addr == `SAC_OFS_VID_EN);
  assign wr_lim_en = i_wr && (i_addr == `SAC_OFS_LIM_EN);
  assign wr_ret = i_wr && (i_addr == `SAC_OFS_RET_EN);

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl0_reg <= `SAC_RST_CTRL0;
      vid_en_reg <= `SAC_RST_VID_EN;
      lim_en_reg <= `SAC_RST_LIM_EN;
      ret_en_reg <= `SAC_RST_RET_EN;
    end else begin
      if (wr_ctrl0) begin
        ctrl0_reg <= i_wdata;
      end
      if (wr_vid) begin
        vid_en_reg <= {2'h0, i_wdata[5:0]};
      end
      if (wr_lim_en) begin
        lim_en_reg <= {2'h0, i_wdata[5:0]};
      end
      if (wr_ret) begin
        ret_en_reg <= {1'h0, i_wdata[6:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Named limit fields
  // ----------------------------------------------------------------
  wire [2:0] volt0_upper_limit;
  wire [2:0] volt0_lower_limit;
  wire [2:0] volt1_upper_limit;
  wire [2:0] volt1_lower_limit;
  wire [2:0] temperature_upper_limit;
  wire [2:0] temperature_lower_limit;
  assign volt0_upper_limit = lim_reg[0][`SAC_UPPER_MSB:`SAC_UPPER_LSB];
  assign volt0_lower_limit = lim_reg[0][`SAC_LOWER_MSB:`SAC_LOWER_LSB];
  assign volt1_upper_limit = lim_reg[1][`SAC_UPPER_MSB:`SAC_UPPER_LSB];
  assign volt1_lower_limit = lim_reg[1][`SAC_LOWER_MSB:`SAC_LOWER_LSB];
  assign temperature_upper_limit = lim_reg[2][`SAC_UPPER_MSB:`SAC_UPPER_LSB];
  assign temperature_lower_limit = lim_reg[2][`SAC_LOWER_MSB:`SAC_LOWER_LSB];

  wire [2:0] upper_lim [0:2];
  wire [2:0] lower_lim [0:2];
  assign upper_lim[0] = volt0_upper_limit;
  assign upper_lim[1] = volt1_upper_limit;
  assign upper_lim[2] = temperature_upper_limit;
  assign lower_lim[0] = volt0_lower_limit;
  assign lower_lim[1] = volt1_lower_limit;
  assign lower_lim[2] = temperature_lower_limit;

  // ----------------------------------------------------------------
  // Named alarm enables
  // ----------------------------------------------------------------
  wire missing_frame_valid_alarm_en;
  wire lane_sync_fault_alarm_en;
  wire lane_control_fault_alarm_en;
  wire header_fault_alarm_en;
  wire payload_checksum_alarm_en;
  wire length_fault_alarm_en;
  wire [5:0] video_alarm_en;
  assign missing_frame_valid_alarm_en = vid_en_reg[5];
  assign lane_sync_fault_alarm_en = vid_en_reg[4];
  assign lane_control_fault_alarm_en = vid_en_reg[3];
  assign header_fault_alarm_en = vid_en_reg[2];
  assign payload_checksum_alarm_en = vid_en_reg[1];
  assign length_fault_alarm_en = vid_en_reg[0];
  assign video_alarm_en = {missing_frame_valid_alarm_en, lane_sync_fault_alarm_en,
                           lane_control_fault_alarm_en, header_fault_alarm_en,
                           payload_checksum_alarm_en, length_fault_alarm_en};

  wire temperature_above_alarm_en;
  wire temperature_below_alarm_en;
  wire volt1_above_alarm_en;
  wire volt1_below_alarm_en;
  wire volt0_above_alarm_en;
  wire volt0_below_alarm_en;
  wire [5:0] limit_alarm_en;
  assign temperature_above_alarm_en = lim_en_reg[5];
  assign temperature_below_alarm_en = lim_en_reg[4];
  assign volt1_above_alarm_en = lim_en_reg[3];
  assign volt1_below_alarm_en = lim_en_reg[2];
  assign volt0_above_alarm_en = lim_en_reg[1];
  assign volt0_below_alarm_en = lim_en_reg[0];
  assign limit_alarm_en = {temperature_above_alarm_en, temperature_below_alarm_en,
                           volt1_above_alarm_en, volt1_below_alarm_en,
                           volt0_above_alarm_en, volt0_below_alarm_en};

  wire return_target_timeout_alarm_en;
  wire return_target_fault_alarm_en;
  wire return_controller_timeout_alarm_en;
  wire return_controller_fault_alarm_en;
  wire return_data_fault_alarm_en;
  wire link_crc_fault_alarm_en;
  wire link_detect_alarm_en;
  wire [6:0] return_alarm_en;
  assign return_target_timeout_alarm_en = ret_en_reg[6];
  assign return_target_fault_alarm_en = ret_en_reg[5];
  assign return_controller_timeout_alarm_en = ret_en_reg[4];
  assign return_controller_fault_alarm_en = ret_en_reg[3];
  assign return_data_fault_alarm_en = ret_en_reg[2];
  assign link_crc_fault_alarm_en = ret_en_reg[1];
  assign link_detect_alarm_en = ret_en_reg[0];
  assign return_alarm_en = {return_target_timeout_alarm_en, return_target_fault_alarm_en,
                            return_controller_timeout_alarm_en,
                            return_controller_fault_alarm_en, return_data_fault_alarm_en,
                            link_crc_fault_alarm_en, link_detect_alarm_en};

  // ----------------------------------------------------------------
  // Sensor enable and channel select
  // ----------------------------------------------------------------
  wire sensors_on;
  wire [2:0] chan_active;
  assign sensors_on = (ctrl0_reg[`SAC_EN_MSB:`SAC_EN_LSB] == `SAC_SENSE_ON);
  assign chan_active = {sensors_on,
                        sensors_on & ctrl0_reg[`SAC_SEL_LSB + 1],
                        sensors_on & ctrl0_reg[`SAC_SEL_LSB]};

  // ----------------------------------------------------------------
  // Per-source limits, flags and extremes
  // ----------------------------------------------------------------
  reg [1:0] flag_reg [0:2];
  reg [2:0] peak_reg [0:1];
  reg [2:0] floor_reg [0:1];
  wire [5:0] status;
  wire clr_status;
  assign clr_status = i_rd && (i_addr == `SAC_OFS_STATUS);

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_src
      wire [2:0] upper;
      wire [2:0] lower;
      wire above;
      wire below;
      wire wr_lim;
      localparam [31:0] LIM_OFS = `SAC_OFS_V0_LIM + g;
      assign upper = upper_lim[g];
      assign lower = lower_lim[g];
      assign above = meas_valid && chan_active[g] && (lvl[g] > upper);
      assign below = meas_valid && chan_active[g] && (lvl[g] < lower);
      assign wr_lim = i_wr && ({24'h000000, i_addr} == LIM_OFS);

      always @(posedge i_sys_clk) begin
        if (i_rst) begin
          lim_reg[g] <= `SAC_RST_LIM;
          flag_reg[g] <= 2'h0;
        end else begin
          if (wr_lim) begin
            lim_reg[g] <= i_wdata;
          end
          // flags set regardless of alarm enable, but only while the channel is active; set beats read clear
          flag_reg[g] <= (clr_status ? 2'h0 : flag_reg[g]) | {above, below};
        end
      end

      if (g < 2) begin : g_ext
        always @(posedge i_sys_clk) begin
          if (i_rst) begin
            peak_reg[g] <= 3'h0;
            floor_reg[g] <= 3'h7;
          end else if (meas_valid && chan_active[g]) begin
            if (lvl[g] > peak_reg[g]) begin
              peak_reg[g] <= lvl[g];
            end
            if (lvl[g] < floor_reg[g]) begin
              floor_reg[g] <= lvl[g];
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Named status flags and extremes
  // ----------------------------------------------------------------
  wire volt0_high_flag;
  wire volt0_low_flag;
  wire volt1_high_flag;
  wire volt1_low_flag;
  wire temperature_high_flag;
  wire temperature_low_flag;
  assign volt0_high_flag = flag_reg[0][1];
  assign volt0_low_flag = flag_reg[0][0];
  assign volt1_high_flag = flag_reg[1][1];
  assign volt1_low_flag = flag_reg[1][0];
  assign temperature_high_flag = flag_reg[2][1];
  assign temperature_low_flag = flag_reg[2][0];
  assign status = {temperature_high_flag, temperature_low_flag, volt1_high_flag,
                   volt1_low_flag, volt0_high_flag, volt0_low_flag};

  wire [2:0] volt0_peak_reading;
  wire [2:0] volt0_floor_reading;
  wire [2:0] volt1_peak_reading;
  wire [2:0] volt1_floor_reading;
  assign volt0_peak_reading = peak_reg[0];
  assign volt0_floor_reading = floor_reg[0];
  assign volt1_peak_reading = peak_reg[1];
  assign volt1_floor_reading = floor_reg[1];

  // ----------------------------------------------------------------
  // Alarm output
  // ----------------------------------------------------------------
  wire [5:0] live_limit;
  assign live_limit = {g_src[2].above, g_src[2].below, g_src[1].above, g_src[1].below,
                       g_src[0].above, g_src[0].below};
  reg alarm_reg;
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      alarm_reg <= 1'b0;
    end else begin
      alarm_reg <= |(live_limit & limit_alarm_en) |
                   |(video_fault & video_alarm_en) |
                   |(return_fault & return_alarm_en);
    end
  end
  assign o_alarm = alarm_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  reg [7:0] rdata_next;
  // Data stands one cycle after the strobe, zero otherwise
  always @* begin
    rdata_next = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `SAC_OFS_CTRL0: rdata_next = ctrl0_reg;
        `SAC_OFS_V0_LIM: rdata_next = lim_reg[0];
        `SAC_OFS_V1_LIM: rdata_next = lim_reg[1];
        `SAC_OFS_T_LIM: rdata_next = lim_reg[2];
        `SAC_OFS_VID_EN: rdata_next = vid_en_reg;
        `SAC_OFS_LIM_EN: rdata_next = lim_en_reg;
        `SAC_OFS_RET_EN: rdata_next = ret_en_reg;
        `SAC_OFS_STATUS: rdata_next = {2'h0, status};
        `SAC_OFS_V0_PEAK: rdata_next = {5'h00, volt0_peak_reading};
        `SAC_OFS_V0_FLOOR: rdata_next = {5'h00, volt0_floor_reading};
        `SAC_OFS_V1_PEAK: rdata_next = {5'h00, volt1_peak_reading};
        `SAC_OFS_V1_FLOOR: rdata_next = {5'h00, volt1_floor_reading};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_next;
    end
  end

endmodule

`default_nettype wire

// >>> sac_asserts.sv
// Port-level assertions for the sensor alarm configuration block
`timescale 1ns/1ns
`default_nettype none
module sac_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_meas_valid,
  input wire logic [5:0] i_video_fault,
  input wire logic [6:0] i_return_fault,
  input wire logic [7:0] o_rdata,
  input wire logic o_alarm
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  rd_idle_a:
    assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
  lim_rw_a:
    assert property (i_wr && i_addr inside {8'h19, 8'h1A, 8'h1B} ##1 i_rd && $stable(i_addr)
      |=> o_rdata == $past(i_wdata, 2)) else $error("limit readback wrong");
  vid_rw_a:
    assert property (i_wr && i_addr inside {8'h1C, 8'h1D} ##1 i_rd && $stable(i_addr)
      |=> o_rdata == {2'h0, $past(i_wdata[5:0], 2)}) else $error("enable readback wrong");
  ret_rw_a:
    assert property (i_wr && i_addr == 8'h1E ##1 i_rd && $stable(i_addr)
      |=> o_rdata == {1'b0, $past(i_wdata[6:0], 2)}) else $error("return readback wrong");
  alarm_quiet_a:
    assert property ((i_video_fault == 6'h00 && i_return_fault == 7'h00 && !i_meas_valid) [*5]
      |-> !o_alarm) else $error("alarm without cause");
  stat_clear_a:
    assert property (!i_meas_valid [*5] ##0 i_rd && i_addr == 8'h40 ##1 i_rd && i_addr == 8'h40
      |=> o_rdata == 8'h00) else $error("status not cleared");
  peak_span_a:
    assert property (i_rd && i_addr inside {8'h41, 8'h43} |=> o_rdata[7:3] == 5'h00)
      else $error("peak out of range");
  unmapped_a:
    assert property (i_rd && i_addr == 8'h1F |=> o_rdata == 8'h00) else $error("unmapped read");
endmodule
bind sac_sensor_alarm_config sac_asserts sac_asserts_inst (.i_sys_clk(i_sys_clk),
  .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .i_meas_valid(i_meas_valid), .i_video_fault(i_video_fault),
  .i_return_fault(i_return_fault), .o_rdata(o_rdata), .o_alarm(o_alarm));
`default_nettype wire

// >>> sac_sensor_alarm_config_test.sv
// Self-checking bench for the sensor alarm configuration block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module sac_sensor_alarm_config_test;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_meas_valid = 1'b0;
  logic pend = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, ev;
  logic [2:0] i_volt0_level = 3'h0, i_volt1_level = 3'h0, i_temp_level = 3'h0;
  logic [5:0] i_video_fault = 6'h00;
  logic [6:0] i_return_fault = 7'h00;
  logic [12:0] m;
  wire [7:0] o_rdata;
  wire o_alarm;
  logic [7:0] exp_q [$];
  logic [31:0] seed = 32'hAB67E1E7;
  logic [7:0] ctl [4] = '{8'h0F, 8'h0F, 8'h0D, 8'h01};
  logic [8:0] lvl [4] = '{9'h1CF, 9'h078, 9'h078, 9'h1FF};
  logic [7:0] st [4] = '{8'h26, 8'h19, 8'h11, 8'h00};
  int error_cnt = 0, checks = 0, i;
  sac_sensor_alarm_config sac_sensor_alarm_config_inst (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_meas_valid(i_meas_valid), .i_volt0_level(i_volt0_level),
    .i_volt1_level(i_volt1_level), .i_temp_level(i_temp_level),
    .i_video_fault(i_video_fault), .i_return_fault(i_return_fault), .o_alarm(o_alarm));
  initial forever #2 i_sys_clk = ~i_sys_clk;
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task wr(input [7:0] a, input [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  // Notes the expected data; the monitor compares it one cycle later
  task rd(input [7:0] a, input [7:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    exp_q.push_back(e);
    @(posedge i_sys_clk);
  endtask
  task idle(input int n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
  endtask
  task achk(input logic e);
    @(negedge i_sys_clk);
    `CHK(o_alarm, e)
    @(posedge i_sys_clk);
  endtask
  task results;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_sys_clk) pend <= i_rd;
  always @(negedge i_sys_clk) begin
    if (pend) begin
      ev = exp_q.pop_front();
      `CHK(o_rdata, ev)
    end
  end
  initial begin
    repeat (2000) @(posedge i_sys_clk);
    error_cnt++;
    results();
  end
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(8'h17, 8'h3C);
    rd(8'h19, 8'h62);
    rd(8'h1A, 8'h62);
    rd(8'h1B, 8'h62);
    rd(8'h1C, 8'h3F);
    rd(8'h1D, 8'h00);
    rd(8'h1E, 8'h00);
    rd(8'h1F, 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h40, 8'h00);
    $display("test reset values done");
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr(8'(8'h19 + i), seed[7:0]);
      rd(8'(8'h19 + i), seed[7:0] & (i < 3 ? 8'hFF : i < 5 ? 8'h3F : 8'h7F));
    end
    $display("test readback done");
    for (i = 0; i < 3; i++) wr(8'(8'h19 + i), 8'h62);
    for (i = 0; i < 4; i++) begin
      wr(8'h17, ctl[i]);
      idle(1);
      {i_volt0_level, i_volt1_level, i_temp_level} <= lvl[i];
      i_meas_valid <= 1'b1;
      idle(5);
      i_meas_valid <= 1'b0;
      idle(5);
      rd(8'h40, st[i]);
      rd(8'h40, 8'h00);
    end
    rd(8'h41, 8'h07);
    rd(8'h42, 8'h01);
    rd(8'h43, 8'h07);
    rd(8'h44, 8'h01);
    $display("test limit crossings done");
    for (i = 0; i < 13; i++) begin
      m = 13'h0001 << i;
      {i_return_fault, i_video_fault} <= m;
      wr(8'h1C, {2'h0, ~m[5:0]});
      wr(8'h1E, {1'b0, ~m[12:6]});
      idle(5);
      achk(1'b0);
      wr(8'h1C, {2'h0, m[5:0]});
      wr(8'h1E, {1'b0, m[12:6]});
      idle(5);
      achk(1'b1);
    end
    {i_return_fault, i_video_fault} <= 13'h0000;
    wr(8'h17, 8'h0F);
    i_meas_valid <= 1'b1;
    wr(8'h1D, 8'h15);
    idle(5);
    achk(1'b0);
    wr(8'h1D, 8'h2A);
    idle(5);
    achk(1'b1);
    $display("test alarm enables done");
    idle(2);
    results();
  end
endmodule
`default_nettype wire
